// *** rtl/ilod_pkg.sv ***
package ilod_pkg;

  // Quarter phases of one instruction cycle
  typedef enum logic [1:0] {
    ILOD_Q1,
    ILOD_Q2,
    ILOD_Q3,
    ILOD_Q4
  } ilod_phase_t;

  // Decoded operation of the latched instruction
  typedef enum logic [1:0] {
    ILOD_OP_NONE,
    ILOD_OP_ADD,
    ILOD_OP_BSET,
    ILOD_OP_FILL
  } ilod_op_t;

  // Widths
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned BANK_W = 4;

  // Operand limits and access bank layout
  localparam logic [7:0]        OFFSET_LIMIT  = 8'h5F;
  localparam logic [7:0]        ACCESS_SPLIT  = 8'h60;
  localparam logic [BANK_W-1:0] ACCESS_LO_BNK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI_BNK = 4'hF;

  // Opcode patterns and field positions
  localparam logic [5:0] ADD_OPC   = 6'h09;
  localparam logic [3:0] BSET_OPC  = 4'h8;
  localparam logic [6:0] FILL_OPC  = 7'h34;
  localparam int unsigned D_POS    = 9;
  localparam int unsigned A_POS    = 8;
  localparam int unsigned B_LSB    = 9;

  // Fill value and status bit positions
  localparam logic [7:0] FILL_VAL  = 8'hFF;
  localparam int unsigned ST_C     = 0;
  localparam int unsigned ST_DC    = 1;
  localparam int unsigned ST_Z     = 2;
  localparam int unsigned ST_OV    = 3;
  localparam int unsigned ST_N     = 4;

  // Values after reset
  localparam logic [7:0] WREG_RST   = 8'h00;
  localparam logic [4:0] STATUS_RST = 5'h00;
  localparam logic       EXT_RST    = 1'b0;

endpackage

// *** rtl/ilod_addr_gen.sv ***
`timescale 1ns/1ps
module ilod_addr_gen (
  // Mode and operand
  input  wire logic                          ext_en,
  input  wire logic                          access_sel,
  input  wire logic [7:0]                    file_op,
  // Pointer and bank
  input  wire logic [ilod_pkg::ADDR_W-1:0]   frame_ptr,
  input  wire logic [ilod_pkg::BANK_W-1:0]   bank_sel,
  // Result
  output logic      [ilod_pkg::ADDR_W-1:0]   data_addr,
  output logic                               indexed
);

  // Offset mode only with extension on, select bit clear, small operand
  assign indexed = ext_en && !access_sel &&
                   (file_op <= ilod_pkg::OFFSET_LIMIT); // [RULE_01] [RULE_03]

  // Pointer plus offset, else bank or access location
  always_comb begin
    if (indexed) begin
      data_addr = frame_ptr + {4'h0, file_op}; // [RULE_02]
    end else if (access_sel) begin
      data_addr = {bank_sel, file_op}; // [RULE_10]
    end else if (file_op < ilod_pkg::ACCESS_SPLIT) begin
      data_addr = {ilod_pkg::ACCESS_LO_BNK, file_op}; // [RULE_10]
    end else begin
      data_addr = {ilod_pkg::ACCESS_HI_BNK, file_op};
    end
  end

endmodule

// *** rtl/ilod_core.sv ***
`timescale 1ns/1ps
// Contract
// RULE_01 - Extension on: file operand up to 5Fh is an offset.
// RULE_02 - Indexed address is stack frame pointer plus offset, not access bank.
// RULE_03 - Offset meaning applies only with select bit zero, taken as zero.
// RULE_04 - Destination bit 0 writes accumulator, 1 writes the indexed location.
// RULE_05 - Add accumulator to indexed byte, updating N, OV, C, DC, Z.
// RULE_06 - Set selected bit of indexed byte; flags unchanged.
// RULE_07 - Write FFh to indexed byte; flags unchanged.
// RULE_08 - One word, one cycle: decode, read, process, write in quarters.
// RULE_09 - Configuration bit enables extension; zero after reset disables it. Decode uses the input bit directly; reset clears only ext_q.
// RULE_10 - Extension off: select zero is access bank, one is bank register.
module ilod_core (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          sys_rst,
  // Configuration
  input  wire logic                          extension_config_bit,
  // Instruction fetch
  input  wire logic                          instr_valid,
  input  wire logic [15:0]                   instr_word,
  // Core pointer and bank
  input  wire logic [ilod_pkg::ADDR_W-1:0]   stack_frame_pointer,
  input  wire logic [ilod_pkg::BANK_W-1:0]   bank_select,
  // Accumulator load from the rest of the core
  input  wire logic                          w_load_en,
  input  wire logic [7:0]                    w_load_data,
  // Data memory
  input  wire logic [7:0]                    mem_rdata,
  output logic      [ilod_pkg::ADDR_W-1:0]   mem_addr_q,
  output logic                               mem_rd_q,
  output logic                               mem_wr_q,
  output logic      [7:0]                    mem_wdata_q,
  // Core state
  output logic                               q1_q,
  output logic                               indexed_q,
  output logic                               unknown_q,
  output logic      [7:0]                    wreg_q,
  output logic      [4:0]                    status_q
);

  ilod_pkg::ilod_phase_t phase_q;
  ilod_pkg::ilod_op_t    op_q;
  ilod_pkg::ilod_op_t    op_dec;
  logic                  ext_q;
  logic                  dest_q;
  logic [2:0]            bit_q;
  logic [7:0]            rdata_q;
  logic [ilod_pkg::ADDR_W-1:0] addr_dec;
  logic                  idx_dec;
  logic [8:0]            sum9;
  logic [4:0]            half5;
  logic [7:0]            bset_val;

  // Opcode decode of the fetched word
  always_comb begin
    if (instr_word[15:10] == ilod_pkg::ADD_OPC) begin
      op_dec = ilod_pkg::ILOD_OP_ADD;
    end else if (instr_word[15:12] == ilod_pkg::BSET_OPC) begin
      op_dec = ilod_pkg::ILOD_OP_BSET;
    end else if (instr_word[15:9] == ilod_pkg::FILL_OPC) begin
      op_dec = ilod_pkg::ILOD_OP_FILL;
    end else begin
      op_dec = ilod_pkg::ILOD_OP_NONE;
    end
  end

  // Effective address; the word decodes with the mode bit presented beside it
  ilod_addr_gen ilod_addr_gen_inst (
    .ext_en     (extension_config_bit), // [RULE_09]
    .access_sel (instr_word[ilod_pkg::A_POS]),
    .file_op    (instr_word[7:0]),
    .frame_ptr  (stack_frame_pointer),
    .bank_sel   (bank_select),
    .data_addr  (addr_dec),
    .indexed    (idx_dec)
  );

  // Quarter phase sequencer, free running
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      phase_q <= ilod_pkg::ILOD_Q1;
      q1_q    <= 1'b1;
    end else begin
      case (phase_q)
        ilod_pkg::ILOD_Q1: phase_q <= ilod_pkg::ILOD_Q2; // [RULE_08]
        ilod_pkg::ILOD_Q2: phase_q <= ilod_pkg::ILOD_Q3;
        ilod_pkg::ILOD_Q3: phase_q <= ilod_pkg::ILOD_Q4;
        ilod_pkg::ILOD_Q4: phase_q <= ilod_pkg::ILOD_Q1;
        default:           phase_q <= ilod_pkg::ILOD_Q1;
      endcase
      q1_q <= (phase_q == ilod_pkg::ILOD_Q4);
    end
  end

  // Extension enable, cleared by reset, refreshed each cycle start
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ext_q <= ilod_pkg::EXT_RST; // [RULE_09]
    end else if (phase_q == ilod_pkg::ILOD_Q1) begin
      ext_q <= extension_config_bit; // [RULE_09]
    end
  end

  // Decode in Q1: latch operation, fields and address
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      op_q       <= ilod_pkg::ILOD_OP_NONE;
      dest_q     <= 1'b0;
      bit_q      <= 3'h0;
      mem_addr_q <= '0;
      indexed_q  <= 1'b0;
      unknown_q  <= 1'b0;
    end else if (phase_q == ilod_pkg::ILOD_Q1) begin
      op_q       <= instr_valid ? op_dec : ilod_pkg::ILOD_OP_NONE;
      dest_q     <= instr_word[ilod_pkg::D_POS];
      bit_q      <= instr_word[ilod_pkg::B_LSB +: 3];
      mem_addr_q <= addr_dec; // [RULE_02]
      indexed_q  <= instr_valid && (op_dec != ilod_pkg::ILOD_OP_NONE) && idx_dec;
      unknown_q  <= instr_valid && (op_dec == ilod_pkg::ILOD_OP_NONE);
    end else if (phase_q == ilod_pkg::ILOD_Q4) begin
      unknown_q  <= 1'b0;
    end
  end

  // Operand read strobe stands through Q2
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mem_rd_q <= 1'b0;
    end else begin
      mem_rd_q <= (phase_q == ilod_pkg::ILOD_Q1) && instr_valid &&
                  (op_dec != ilod_pkg::ILOD_OP_NONE); // [RULE_08]
    end
  end

  // Arithmetic for the add and bit set operations
  assign sum9     = {1'b0, wreg_q} + {1'b0, mem_rdata};
  assign half5    = {1'b0, wreg_q[3:0]} + {1'b0, mem_rdata[3:0]};
  assign bset_val = mem_rdata | (8'h01 << bit_q);

  // Process in Q3: capture operand, form result for write-back
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q     <= 8'h00;
      mem_wr_q    <= 1'b0;
      mem_wdata_q <= 8'h00;
    end else if (phase_q == ilod_pkg::ILOD_Q3) begin
      rdata_q <= mem_rdata;
      case (op_q)
        ilod_pkg::ILOD_OP_ADD: begin
          mem_wr_q    <= dest_q; // [RULE_04]
          mem_wdata_q <= sum9[7:0]; // [RULE_05]
        end
        ilod_pkg::ILOD_OP_BSET: begin
          mem_wr_q    <= 1'b1;
          mem_wdata_q <= bset_val; // [RULE_06]
        end
        ilod_pkg::ILOD_OP_FILL: begin
          mem_wr_q    <= 1'b1;
          mem_wdata_q <= ilod_pkg::FILL_VAL; // [RULE_07]
        end
        default: begin
          mem_wr_q    <= 1'b0;
        end
      endcase
    end else begin
      mem_wr_q <= 1'b0;
    end
  end

  // Accumulator: add result with destination 0 wins over external load
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wreg_q <= ilod_pkg::WREG_RST;
    end else if ((phase_q == ilod_pkg::ILOD_Q3) && (op_q == ilod_pkg::ILOD_OP_ADD) &&
                 !dest_q) begin
      wreg_q <= sum9[7:0]; // [RULE_04]
    end else if (w_load_en) begin
      wreg_q <= w_load_data;
    end
  end

  // Status flags change only for the add
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status_q <= ilod_pkg::STATUS_RST;
    end else if ((phase_q == ilod_pkg::ILOD_Q3) && (op_q == ilod_pkg::ILOD_OP_ADD)) begin
      status_q[ilod_pkg::ST_C]  <= sum9[8]; // [RULE_05]
      status_q[ilod_pkg::ST_DC] <= half5[4];
      status_q[ilod_pkg::ST_Z]  <= (sum9[7:0] == 8'h00);
      status_q[ilod_pkg::ST_N]  <= sum9[7];
      status_q[ilod_pkg::ST_OV] <= (wreg_q[7] == mem_rdata[7]) && (sum9[7] != wreg_q[7]);
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_read;
    mem_rd_q && (phase_q == ilod_pkg::ILOD_Q2);
  endsequence

  sequence s_store;
    mem_wr_q && (phase_q == ilod_pkg::ILOD_Q4);
  endsequence

  AST_PHASE_ORDER: assert property ((phase_q == ilod_pkg::ILOD_Q1) |=> // [RULE_08]
    (phase_q == ilod_pkg::ILOD_Q2) ##1 (phase_q == ilod_pkg::ILOD_Q3) ##1
    (phase_q == ilod_pkg::ILOD_Q4)) else $error("quarter phases out of order");

  AST_READ_IN_Q2: assert property (mem_rd_q |-> s_read) // [RULE_08]
    else $error("operand read outside Q2");

  AST_FILL_STORE: assert property (s_read and (op_q == ilod_pkg::ILOD_OP_FILL) |-> // [RULE_07]
    ##2 (s_store and (mem_wdata_q == 8'hFF) and (mem_addr_q == $past(mem_addr_q, 2))))
    else $error("fill did not store all ones");

  AST_BSET_STORE: assert property (s_read and (op_q == ilod_pkg::ILOD_OP_BSET) |-> // [RULE_06]
    ##2 (s_store and (mem_wdata_q == (rdata_q | (8'h01 << bit_q)))))
    else $error("bit set wrote wrong byte");

  AST_INDEX_LIMIT: assert property ((phase_q == ilod_pkg::ILOD_Q2) && indexed_q |-> // [RULE_01]
    ext_q && !$past(instr_word[ilod_pkg::A_POS]) &&
    ($past(instr_word[7:0]) <= ilod_pkg::OFFSET_LIMIT) &&
    (mem_addr_q == $past(stack_frame_pointer) + {4'h0, $past(instr_word[7:0])}))
    else $error("bad indexed address");

  AST_DISABLED_NO_INDEX: assert property (!extension_config_bit && // [RULE_09]
    (phase_q == ilod_pkg::ILOD_Q1) |=> !indexed_q) else $error("indexed while extension off");

  AST_ADD_TO_W: assert property (s_read and (op_q == ilod_pkg::ILOD_OP_ADD) && !dest_q // [RULE_04]
    |=> ##1 !mem_wr_q && (wreg_q == $past(wreg_q) + rdata_q))
    else $error("add to accumulator wrong");

  AST_ADD_ZERO: assert property (s_read and (op_q == ilod_pkg::ILOD_OP_ADD) |-> // [RULE_05]
    ##2 (status_q[ilod_pkg::ST_Z] == ((($past(wreg_q) + rdata_q) & 8'hFF) == 8'h00)))
    else $error("zero flag wrong after add");

  AST_FLAGS_KEPT: assert property ((op_q != ilod_pkg::ILOD_OP_ADD) && // [RULE_06] [RULE_07]
    (phase_q == ilod_pkg::ILOD_Q3) |=> $stable(status_q))
    else $error("flags changed without add");

endmodule

// *** tb/ilod_core_test.sv ***
`timescale 1ns/1ps
module ilod_core_test;
  // Expected outcome of one instruction
  typedef struct {
    logic [11:0] addr;
    logic        rd;
    logic        idx;
    logic [7:0]  rdata;
    logic        wr;
    logic [7:0]  wdata;
    logic [7:0]  wreg;
    logic [4:0]  status;
  } ilod_exp_t;

  logic        mclk, sys_rst, extension_config_bit, instr_valid, w_load_en;
  logic [15:0] instr_word;
  logic [11:0] stack_frame_pointer, mem_addr_q;
  logic [3:0]  bank_select;
  logic [7:0]  w_load_data, mem_rdata, mem_wdata_q, wreg_q, w_exp;
  logic [4:0]  status_q, st_exp;
  logic        mem_rd_q, mem_wr_q, q1_q, indexed_q, unknown_q;
  logic [31:0] seed = 32'h11;
  int          error_cnt = 0;
  int          n_tests = 0;
  ilod_exp_t   exp_q[$];

  ilod_core ilod_core_inst (.mclk(mclk), .sys_rst(sys_rst),
    .extension_config_bit(extension_config_bit), .instr_valid(instr_valid),
    .instr_word(instr_word), .stack_frame_pointer(stack_frame_pointer),
    .bank_select(bank_select), .w_load_en(w_load_en), .w_load_data(w_load_data),
    .mem_rdata(mem_rdata), .mem_addr_q(mem_addr_q), .mem_rd_q(mem_rd_q),
    .mem_wr_q(mem_wr_q), .mem_wdata_q(mem_wdata_q), .q1_q(q1_q), .indexed_q(indexed_q),
    .unknown_q(unknown_q), .wreg_q(wreg_q), .status_q(status_q));

  // Clock, 10 ns period
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Note the expectation, then present the word in a Q1 cycle
  task automatic issue(input logic [15:0] word, input logic ext, input logic [11:0] ptr,
                       input logic [3:0] bnk, input logic ld, input logic [7:0] ldv,
                       input logic [7:0] m);
    ilod_exp_t  e;
    logic [7:0] f;
    logic [8:0] s;
    logic [4:0] h;
    int         i;
    f = word[7:0];
    e.idx = ext && !word[8] && f <= ilod_pkg::OFFSET_LIMIT;
    e.addr = e.idx ? ptr + 12'(f) : word[8] ? {bnk, f} :
             (f < ilod_pkg::ACCESS_SPLIT ? {4'h0, f} : {4'hF, f});
    if (ld) w_exp = ldv;
    e.rd = 1'b1;
    e.rdata = m;
    e.wr = 1'b0;
    e.wdata = 8'h00;
    if (word[15:10] == ilod_pkg::ADD_OPC) begin
      s = {1'b0, w_exp} + {1'b0, m};
      h = {1'b0, w_exp[3:0]} + {1'b0, m[3:0]};
      st_exp[ilod_pkg::ST_C] = s[8];
      st_exp[ilod_pkg::ST_DC] = h[4];
      st_exp[ilod_pkg::ST_Z] = (s[7:0] == 8'h00);
      st_exp[ilod_pkg::ST_OV] = (w_exp[7] == m[7]) && (s[7] != w_exp[7]);
      st_exp[ilod_pkg::ST_N] = s[7];
      e.wr = word[9];
      e.wdata = s[7:0];
      if (!word[9]) w_exp = s[7:0];
    end else if (word[15:12] == ilod_pkg::BSET_OPC) begin
      e.wr = 1'b1;
      e.wdata = m | (8'h01 << word[11:9]);
    end else if (word[15:9] == ilod_pkg::FILL_OPC) begin
      e.wr = 1'b1;
      e.wdata = ilod_pkg::FILL_VAL;
    end else begin
      e.rd = 1'b0;
      e.idx = 1'b0;
    end
    e.wreg = w_exp;
    e.status = st_exp;
    exp_q.push_back(e);
    i = 0;
    @(negedge mclk);
    while (q1_q !== 1'b1 && i < 8) begin
      @(negedge mclk);
      i++;
    end
    instr_valid = 1'b1;
    instr_word = word;
    extension_config_bit = ext;
    stack_frame_pointer = ptr;
    bank_select = bnk;
    w_load_en = ld;
    w_load_data = ldv;
    @(negedge mclk);
    instr_valid = 1'b0;
    w_load_en = 1'b0;
    s = 9'(rnd());
    instr_word = {~word[15:9], s[8:0]};
  endtask

  // Monitor: memory answer and comparison against the oldest note
  initial begin
    ilod_exp_t e;
    forever begin
      @(negedge mclk);
      if (mem_rd_q === 1'b1 || unknown_q === 1'b1) begin
        if (exp_q.size() == 0) begin
          check("spurious", 16'h1, 16'h0);
        end else begin
          e = exp_q.pop_front();
          check("q1", 16'(q1_q), 16'h0);
          check("mem_rd", 16'(mem_rd_q), 16'(e.rd));
          check("unknown", 16'(unknown_q), 16'(!e.rd));
          check("indexed", 16'(indexed_q), 16'(e.idx));
          if (e.rd) check("addr", 16'(mem_addr_q), 16'(e.addr));
          // Operand stands through Q3, taken at the edge ending Q3
          mem_rdata = e.rdata;
          repeat (2) @(negedge mclk);
          mem_rdata = ~e.rdata;
          check("mem_wr", 16'(mem_wr_q), 16'(e.wr));
          if (e.wr) check("wdata", 16'(mem_wdata_q), 16'(e.wdata));
          if (e.wr) check("wr_addr", 16'(mem_addr_q), 16'(e.addr));
          check("wreg", 16'(wreg_q), 16'(e.wreg));
          check("status", 16'(status_q), 16'(e.status));
        end
      end
    end
  end

  // Watchdog
  initial begin
    #20000;
    error_cnt++;
    final_report();
  end

  // Main sequence
  initial begin
    logic [31:0] r, q;
    logic [15:0] w;
    {sys_rst, extension_config_bit, instr_valid, w_load_en} = 4'h8;
    instr_word = 16'h0000;
    stack_frame_pointer = 12'h000;
    bank_select = 4'h0;
    w_load_data = 8'h00;
    mem_rdata = 8'h00;
    w_exp = ilod_pkg::WREG_RST;
    st_exp = ilod_pkg::STATUS_RST;
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    issue(16'h2405, 1'b0, 12'hA00, 4'h3, 1'b0, 8'h00, 8'h11);
    issue(16'h242C, 1'b1, 12'hA00, 4'h0, 1'b1, 8'h17, 8'h20);
    issue(16'h8E0A, 1'b1, 12'hA00, 4'h0, 1'b0, 8'h00, 8'h55);
    issue(16'h682C, 1'b1, 12'hA00, 4'h0, 1'b0, 8'h00, 8'h00);
    issue(16'h265F, 1'b1, 12'h3F0, 4'h2, 1'b1, 8'h80, 8'h80);
    issue(16'h2460, 1'b1, 12'h3F0, 4'h2, 1'b1, 8'h7F, 8'h01);
    issue(16'h2505, 1'b1, 12'h3F0, 4'h7, 1'b0, 8'h00, 8'h0F);
    issue(16'h0000, 1'b1, 12'h3F0, 4'h7, 1'b0, 8'h00, 8'h0F);
    for (int k = 0; k < 80; k++) begin
      r = rnd();
      q = rnd();
      case (r[1:0])
        2'h0: w = {ilod_pkg::ADD_OPC, r[3:2], r[15:8]};
        2'h1: w = {ilod_pkg::BSET_OPC, r[5:2], r[15:8]};
        2'h2: w = {ilod_pkg::FILL_OPC, r[6], r[15:8]};
        default: w = r[31:16];
      endcase
      issue(w, r[7], q[11:0], q[15:12], q[16], q[24:17], q[31:24]);
    end
    repeat (8) @(negedge mclk);
    check("pending", 16'(exp_q.size()), 16'h0);
    final_report();
  end
endmodule
